// >>> src/tpfc_pkg.sv
// constants for the supply-rail and fault control register bank
package tpfc_pkg;
   localparam logic [7:0] FAULT_CTRL_ADDR    = 8'h1B;
   localparam logic [7:0] RAIL_CTRL_ADDR     = 8'h1C;
   localparam logic [7:0] CONFIG_CHANNEL_STATUS_ADDR     = 8'h1D;
   localparam logic [7:0] FAULT_CTRL_RESET   = 8'h06;
   localparam logic [7:0] RAIL_CTRL_RESET    = 8'h60;
   localparam logic [7:0] FAULT_CTRL_WMASK   = 8'h1E;
   localparam logic [7:0] RAIL_CTRL_WMASK    = 8'h7F;
   localparam int         FC_EXT_SHUTOFF_BIT = 4;
   localparam int         FC_DIS_TIMER_BIT   = 3;
   localparam int         FC_OCP_OFF_BIT     = 2;
   localparam int         FC_OVP_OFF_BIT     = 1;
   localparam int         RC_MEASURE_OFF_BIT = 6;
   localparam int         RC_ALARM_OFF_BIT   = 5;
   localparam int         RC_AUTO_DRAIN_BIT  = 4;
   localparam int         RC_BLEED_BIT       = 3;
   localparam int         RC_FORCE_DRAIN_BIT = 2;
   localparam int         RC_PWR_LEVEL_BIT   = 1;
   localparam int         RC_SOURCE_ON_BIT   = 0;
endpackage

// >>> src/tpfc_top.sv
// fault control, rail control and cc sampling trigger register bank
`timescale 1ns/1ps
// Contract
// - bit 4 of fault control stored only, no function attached.
// - fault bit 3 high disables discharge fault timer; resets low.
// - fault bit 2 overcurrent disable flag, resets 1, no behaviour.
// - fault bit 1 overvoltage disable flag, resets 1, no behaviour.
// - rail bit 6 disables measurement; measurement output reads zero then.
// - rail bit 5 disables high and low alarm reporting.
// - rail bit 4 enables automatic discharge at disconnect.
// - rail bit 3 switches bleed discharge path.
// - rail bit 2 forces discharge until zero or stop level reached.
// - device clears force bit itself once target level reached.
// - rail bit 1 selects committed cable power level.
// - rail bit 0 sources cable power onto orientation-selected pin.
// - reading config_channel_status triggers immediate sample unless pd busy.
// - fault control resets to 06, rail control to 60.
// - orientation 0 routes power to CC2; 1 routes to CC1.
module tpfc_top
   import tpfc_pkg::*;
(
   input  wire logic       REF_CLK_I,
   input  wire logic       RSTN_I,
   input  wire logic       WR_EN_I,
   input  wire logic       RD_EN_I,
   input  wire logic [7:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   output logic      [7:0] RDATA_O,
   input  wire logic [7:0] CONFIG_CHANNEL_STATUS_I,
   input  wire logic       PD_IDLE_I,
   input  wire logic       CONNECTOR_FLIP_SEL_I,
   input  wire logic       DISCONNECT_I,
   input  wire logic       DRAIN_DONE_I,
   input  wire logic [9:0] RAIL_MEASUREMENT_I,
   input  wire logic       RAIL_HIGH_ALARM_I,
   input  wire logic       RAIL_LOW_ALARM_I,
   output logic      [9:0] RAIL_MEASUREMENT_O,
   output logic            RAIL_HIGH_ALARM_O,
   output logic            RAIL_LOW_ALARM_O,
   output logic            FAULT_TIMER_EN_O,
   output logic            MEASURE_EN_O,
   output logic            AUTO_DRAIN_EN_O,
   output logic            BLEED_ON_O,
   output logic            FORCE_DRAIN_O,
   output logic            DRAIN_ACTIVE_O,
   output logic            CABLE_POWER_LEVEL_SEL_O,
   output logic            CABLE_POWER_CC1_O,
   output logic            CABLE_POWER_CC2_O,
   output logic            CC_SAMPLE_NOW_O
);
   import tpfc_pkg::*;

   logic [7:0] fault_reg, fault_next;
   logic [7:0] rail_reg, rail_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [9:0] meas_reg, meas_next;
   logic       hi_reg, hi_next, lo_reg, lo_next;
   logic       drain_reg, drain_next;
   logic       sample_reg, sample_next;
   logic       flip_s1, flip_reg, disc_s1, disc_reg, done_s1, done_reg;
   logic       disc_old_reg;

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         flip_s1      <= 1'b0;
         flip_reg     <= 1'b0;
         disc_s1      <= 1'b0;
         disc_reg     <= 1'b0;
         done_s1      <= 1'b0;
         done_reg     <= 1'b0;
         disc_old_reg <= 1'b0;
      end
      else
      begin
         flip_s1      <= CONNECTOR_FLIP_SEL_I;
         flip_reg     <= flip_s1;
         disc_s1      <= DISCONNECT_I;
         disc_reg     <= disc_s1;
         done_s1      <= DRAIN_DONE_I;
         done_reg     <= done_s1;
         disc_old_reg <= disc_reg;
      end
   end

   always_comb
   begin
      fault_next  = fault_reg;
      rail_next   = rail_reg;
      rdata_next  = rdata_reg;
      drain_next  = drain_reg;
      sample_next = 1'b0;
      // masked writes, reserved bits stay zero
      if (WR_EN_I && ADDR_I == FAULT_CTRL_ADDR)
         fault_next = WDATA_I & FAULT_CTRL_WMASK;
      if (WR_EN_I && ADDR_I == RAIL_CTRL_ADDR)
         rail_next = WDATA_I & RAIL_CTRL_WMASK;
      // hardware clear wins once target reached
      if (done_reg)
         rail_next[RC_FORCE_DRAIN_BIT] = 1'b0;
      if (rail_reg[RC_AUTO_DRAIN_BIT] && disc_reg && !disc_old_reg)
         drain_next = 1'b1;
      else if (done_reg)
         drain_next = 1'b0;
      if (RD_EN_I)
      begin
         unique case (ADDR_I)
            FAULT_CTRL_ADDR: rdata_next = fault_reg;
            RAIL_CTRL_ADDR:  rdata_next = rail_reg;
            CONFIG_CHANNEL_STATUS_ADDR:  rdata_next = CONFIG_CHANNEL_STATUS_I;
            default:         rdata_next = 8'h00;
         endcase
         sample_next = (ADDR_I == CONFIG_CHANNEL_STATUS_ADDR) && PD_IDLE_I;
      end
      meas_next = rail_reg[RC_MEASURE_OFF_BIT] ? 10'h000 : RAIL_MEASUREMENT_I;
      hi_next = !rail_reg[RC_ALARM_OFF_BIT] && RAIL_HIGH_ALARM_I;
      lo_next = !rail_reg[RC_ALARM_OFF_BIT] && RAIL_LOW_ALARM_I;
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         fault_reg  <= FAULT_CTRL_RESET;
         rail_reg   <= RAIL_CTRL_RESET;
         rdata_reg  <= 8'h00;
         meas_reg   <= 10'h000;
         hi_reg     <= 1'b0;
         lo_reg     <= 1'b0;
         drain_reg  <= 1'b0;
         sample_reg <= 1'b0;
      end
      else
      begin
         fault_reg  <= fault_next;
         rail_reg   <= rail_next;
         rdata_reg  <= rdata_next;
         meas_reg   <= meas_next;
         hi_reg     <= hi_next;
         lo_reg     <= lo_next;
         drain_reg  <= drain_next;
         sample_reg <= sample_next;
      end
   end

   assign RDATA_O            = rdata_reg;
   assign RAIL_MEASUREMENT_O = meas_reg;
   assign RAIL_HIGH_ALARM_O  = hi_reg;
   assign RAIL_LOW_ALARM_O   = lo_reg;
   assign CC_SAMPLE_NOW_O    = sample_reg;
   assign FAULT_TIMER_EN_O   = ~fault_reg[FC_DIS_TIMER_BIT];
   assign MEASURE_EN_O       = ~rail_reg[RC_MEASURE_OFF_BIT];
   assign AUTO_DRAIN_EN_O    = rail_reg[RC_AUTO_DRAIN_BIT];
   assign BLEED_ON_O         = rail_reg[RC_BLEED_BIT];
   assign FORCE_DRAIN_O      = rail_reg[RC_FORCE_DRAIN_BIT];
   assign DRAIN_ACTIVE_O     = rail_reg[RC_FORCE_DRAIN_BIT] | drain_reg;
   assign CABLE_POWER_LEVEL_SEL_O = rail_reg[RC_PWR_LEVEL_BIT];
   assign CABLE_POWER_CC1_O  = rail_reg[RC_SOURCE_ON_BIT] & flip_reg;
   assign CABLE_POWER_CC2_O  = rail_reg[RC_SOURCE_ON_BIT] & ~flip_reg;

   property p_reset_values;
      @(posedge REF_CLK_I) $rose(RSTN_I) |-> fault_reg == FAULT_CTRL_RESET
         && rail_reg == RAIL_CTRL_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset values");

   property p_reserved_zero;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
         (fault_reg & ~FAULT_CTRL_WMASK) == 8'h00 && !rail_reg[7];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_fault_write;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
         WR_EN_I && ADDR_I == FAULT_CTRL_ADDR |=> fault_reg == ($past(WDATA_I) & FAULT_CTRL_WMASK);
   endproperty
   a_fault_write: assert property (p_fault_write) else $error("fault write lost");

   property p_timer;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
         WR_EN_I && ADDR_I == FAULT_CTRL_ADDR
         |=> FAULT_TIMER_EN_O == !$past(WDATA_I[FC_DIS_TIMER_BIT]);
   endproperty
   a_timer: assert property (p_timer) else $error("timer enable wrong");

   property p_measure_zero;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
         rail_reg[6] && $past(rail_reg[6]) |-> RAIL_MEASUREMENT_O == 10'h000;
   endproperty
   a_measure_zero: assert property (p_measure_zero) else $error("measure not zero");

   property p_alarm_off;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
         $past(rail_reg[5]) |-> !RAIL_HIGH_ALARM_O && !RAIL_LOW_ALARM_O;
   endproperty
   a_alarm_off: assert property (p_alarm_off) else $error("alarm shown while off");

   property p_force_clear;
      @(posedge REF_CLK_I) disable iff (!RSTN_I) done_reg |=> !rail_reg[2];
   endproperty
   a_force_clear: assert property (p_force_clear) else $error("force bit not cleared");

   property p_steer;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
         !(CABLE_POWER_CC1_O && CABLE_POWER_CC2_O) && (rail_reg[0] == (CABLE_POWER_CC1_O
         | CABLE_POWER_CC2_O));
   endproperty
   a_steer: assert property (p_steer) else $error("cable power steering wrong");

   property p_sample;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
         RD_EN_I && ADDR_I == CONFIG_CHANNEL_STATUS_ADDR && PD_IDLE_I |=> CC_SAMPLE_NOW_O ##1 !CC_SAMPLE_NOW_O
         || $past(RD_EN_I);
   endproperty
   a_sample: assert property (p_sample) else $error("no sample on status read");
endmodule

// >>> sim/tpfc_drain_model.sv
// partner model of the rail discharge path reporting target reached
`timescale 1ns/1ps
module tpfc_drain_model #(
   parameter int DELAY = 4
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic drain_i,
   output logic      done_o
);
   int cnt;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt <= 0;
         done_o <= 1'b0;
      end
      else
      begin
         cnt <= drain_i ? cnt + 1 : 0;
         done_o <= drain_i && (cnt >= DELAY);
      end
   end
endmodule

// >>> sim/tb.sv
// self-checking bench for the rail and fault control bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
   import tpfc_pkg::*;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       wr = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       pd_idle = 1'b1;
   logic       flip = 1'b0;
   logic       disc = 1'b0;
   logic       done;
   logic [7:0] rdata;
   logic [9:0] meas_o;
   logic       hi_o, lo_o, tmr, men, aen, bleed, force_o, act, lvl, cc1, cc2, smp;
   logic [7:0] rv;
   logic       sv;
   int         errors = 0;
   int         num_checks = 0;
   initial forever #2.5 clk = ~clk;
   tpfc_drain_model u_model (.clk_i(clk), .rstn_i(rstn), .drain_i(act), .done_o(done));
   tpfc_top u_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .WR_EN_I(wr), .RD_EN_I(rd_en),
      .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .CONFIG_CHANNEL_STATUS_I(8'h2D),
      .PD_IDLE_I(pd_idle), .CONNECTOR_FLIP_SEL_I(flip), .DISCONNECT_I(disc),
      .DRAIN_DONE_I(done), .RAIL_MEASUREMENT_I(10'h2A5), .RAIL_HIGH_ALARM_I(1'b1),
      .RAIL_LOW_ALARM_I(1'b1), .RAIL_MEASUREMENT_O(meas_o), .RAIL_HIGH_ALARM_O(hi_o),
      .RAIL_LOW_ALARM_O(lo_o), .FAULT_TIMER_EN_O(tmr), .MEASURE_EN_O(men),
      .AUTO_DRAIN_EN_O(aen), .BLEED_ON_O(bleed), .FORCE_DRAIN_O(force_o),
      .DRAIN_ACTIVE_O(act), .CABLE_POWER_LEVEL_SEL_O(lvl), .CABLE_POWER_CC1_O(cc1),
      .CABLE_POWER_CC2_O(cc2), .CC_SAMPLE_NOW_O(smp));
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      rv = rdata;
      sv = smp;
   endtask
   task automatic t_reset();
      rd_reg(FAULT_CTRL_ADDR);
      `CHK("fault reset", 8'h06, rv)
      rd_reg(RAIL_CTRL_ADDR);
      `CHK("rail reset", 8'h60, rv)
      `CHK("timer enable", 1'b1, tmr)
      `CHK("measure enable off", 1'b0, men)
      `CHK("gated measurement", 10'h000, meas_o)
      `CHK("gated alarm", 1'b0, hi_o | lo_o)
   endtask
   task automatic t_fields();
      wr_reg(FAULT_CTRL_ADDR, 8'hFF);
      rd_reg(FAULT_CTRL_ADDR);
      `CHK("fault masked", 8'h1E, rv)
      `CHK("timer disabled", 1'b0, tmr)
      wr_reg(RAIL_CTRL_ADDR, 8'hFA);
      rd_reg(RAIL_CTRL_ADDR);
      `CHK("rail masked", 8'h7A, rv)
      `CHK("bleed and level", 2'b11, {bleed, lvl})
      wr_reg(RAIL_CTRL_ADDR, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      `CHK("measurement", 10'h2A5, meas_o)
      `CHK("alarms", 3'b111, {hi_o, lo_o, men})
      wr_reg(CONFIG_CHANNEL_STATUS_ADDR, 8'hFF);
      rd_reg(8'h40);
      `CHK("unmapped read", 8'h00, rv)
   endtask
   task automatic t_cable();
      wr_reg(RAIL_CTRL_ADDR, 8'h01);
      `CHK("flip 0 routes", 2'b01, {cc1, cc2})
      @(posedge clk);
      flip <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      `CHK("flip 1 routes", 2'b10, {cc1, cc2})
   endtask
   task automatic t_cc();
      rd_reg(CONFIG_CHANNEL_STATUS_ADDR);
      `CHK("cc value", 8'h2D, rv)
      `CHK("sample pulse", 1'b1, sv)
      @(posedge clk);
      #1;
      `CHK("pulse ends", 1'b0, smp)
      @(posedge clk);
      pd_idle <= 1'b0;
      rd_reg(CONFIG_CHANNEL_STATUS_ADDR);
      `CHK("busy no sample", 1'b0, sv)
      @(posedge clk);
      pd_idle <= 1'b1;
   endtask
   task automatic t_drain();
      wr_reg(RAIL_CTRL_ADDR, 8'h04);
      `CHK("force on", 1'b1, force_o)
      for (int i = 0; i < 40 && force_o !== 1'b0; i++) @(posedge clk);
      rd_reg(RAIL_CTRL_ADDR);
      `CHK("force self clear", 8'h00, rv)
      wr_reg(RAIL_CTRL_ADDR, 8'h10);
      `CHK("auto enable", 1'b1, aen)
      @(posedge clk);
      disc <= 1'b1;
      for (int i = 0; i < 40 && act !== 1'b1; i++) @(posedge clk);
      #1;
      `CHK("auto drain", 1'b1, act)
      for (int i = 0; i < 40 && act !== 1'b0; i++) @(posedge clk);
      #1;
      `CHK("auto drain end", 1'b0, act)
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      stop_test();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_fields();
      t_cable();
      t_cc();
      t_drain();
      stop_test();
   end
endmodule
